// ==== dcf_channel_ctrl.sv ====
`timescale 1ns/100ps
module dcf_channel_ctrl (
  input  wire logic                core_clk_in,
  input  wire logic                rstn_in,
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [7:0]          paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic      [31:0]         prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  input  wire logic                ext_transfer_request_in,
  input  wire logic                normal_done_in,
  input  wire logic                abnormal_done_in,
  output logic                     transfer_request_out,
  output logic                     big_endian_out,
  output dcf_pkg::dcf_ch_state_t   channel_state_out,
  output logic                     irq_out
);
  import dcf_pkg::*;

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic              normal_ie;
    logic              abnormal_ie;
    logic              rsvd21;
    logic              big_endian;
    logic              source_sel;
    logic              polarity_sel;
    logic              level_mode;
    dcf_ch_state_t     state;
    logic              xfer_req;
    logic [1:0]        settle;
    logic [IRQ_W-1:0]  irq_en;
    logic [IRQ_W-1:0]  irq_clr;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } dcf_top_st_t;

  dcf_top_st_t      st;
  dcf_top_st_t      next_st;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_event;
  logic             access;
  logic             commit;
  logic             wr_commit;
  logic             addr_hit;
  logic             start_wr;
  logic             ctrl_wr;
  logic             ext_req;
  logic             ext_ok;
  logic [31:0]      ctrl_rd;
  logic [31:0]      rd_data;

  dcf_req_if req_bus ();

  // ==========================================================
  // submodules
  // ==========================================================
  dcf_req_detect u_req_detect (
    .core_clk_in             (core_clk_in),
    .rstn_in                 (rstn_in),
    .ext_transfer_request_in (ext_transfer_request_in),
    .req                     (req_bus.det)
  );

  dcf_irq_status #(
    .N (IRQ_W)
  ) u_irq_status (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .event_in    (irq_event),
    .enable_in   (st.irq_en),
    .clear_in    (st.irq_clr),
    .status_out  (irq_status),
    .irq_out     (irq_out)
  );

  assign req_bus.source_sel   = st.source_sel;
  assign req_bus.polarity_sel = st.polarity_sel;
  assign req_bus.level_mode   = st.level_mode;
  assign ext_req              = req_bus.request;

  // ==========================================================
  // bus decode
  // ==========================================================
  // first access cycle loads the answer, second one completes;
  // writes land only on the edge where the master sees pready
  assign access    = psel_in & penable_in & ~st.pready;
  assign commit    = psel_in & penable_in & st.pready;
  assign wr_commit = commit & pwrite_in & ~st.pslverr;
  assign ctrl_wr   = wr_commit & (paddr_in == ADDR_CTRL);

  always_comb
  begin
    addr_hit = 1'b0;
    unique case (paddr_in)
      ADDR_CTRL:    addr_hit = 1'b1;
      ADDR_STATUS:  addr_hit = 1'b1;
      ADDR_IRQ_CLR: addr_hit = 1'b1;
      ADDR_IRQ_EN:  addr_hit = 1'b1;
      ADDR_CHAN:    addr_hit = 1'b1;
      default:      addr_hit = 1'b0;
    endcase
  end

  assign start_wr = ctrl_wr & pwdata_in[BIT_START];

  // ==========================================================
  // read view
  // ==========================================================
  // the start bit always reads 0; reserved bits other than 21 read 0
  always_comb
  begin
    ctrl_rd                  = 32'h0000_0000;
    ctrl_rd[BIT_NORMAL_IE]   = st.normal_ie;
    ctrl_rd[BIT_ABNORMAL_IE] = st.abnormal_ie;
    ctrl_rd[BIT_RSVD21]      = st.rsvd21;
    ctrl_rd[BIT_BIG_ENDIAN]  = st.big_endian;
    ctrl_rd[BIT_SOURCE_SEL]  = st.source_sel;
    ctrl_rd[BIT_POLARITY]    = st.polarity_sel;
    ctrl_rd[BIT_LEVEL_MODE]  = st.level_mode;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (paddr_in)
      ADDR_CTRL:
      begin
        rd_data = ctrl_rd;
      end
      ADDR_STATUS:
      begin
        rd_data[IRQ_W-1:0] = irq_status;
      end
      ADDR_IRQ_CLR:
      begin
        // write-only: clearing has no state to show
        rd_data = 32'h0000_0000;
      end
      ADDR_IRQ_EN:
      begin
        rd_data[IRQ_W-1:0] = st.irq_en;
      end
      ADDR_CHAN:
      begin
        rd_data[1:0] = st.state;
      end
      default:
      begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // request guard
  // ==========================================================
  // for two cycles after a control write the detector output is still
  // formed with the old polarity and level/edge setting, so a stale
  // request could arm a transfer at the wrong pin level; it is held off
  // meanwhile. limitation: a genuine edge inside those two cycles is
  // lost, while a level request is merely seen a little later
  assign ext_ok = ext_req & (st.settle == 2'h0);

  // ==========================================================
  // interrupt events
  // ==========================================================
  // completion events are dropped, not deferred, while their enable is 0
  always_comb
  begin
    irq_event               = '0;
    irq_event[IRQ_NORMAL]   = normal_done_in & st.normal_ie;
    irq_event[IRQ_ABNORMAL] = abnormal_done_in & st.abnormal_ie;
    irq_event[IRQ_EXT_REQ]  = ext_ok & (st.state == DCF_READY);
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb
  begin
    next_st          = st;
    next_st.xfer_req = 1'b0;
    next_st.irq_clr  = '0;

    // bus answer
    if (access)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = ~addr_hit;
      next_st.prdata  = pwrite_in ? 32'h0000_0000 : rd_data;
    end
    else if (commit)
    begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0000_0000;
    end

    // register writes
    if (wr_commit)
    begin
      unique case (paddr_in)
        ADDR_CTRL:
        begin
          next_st.normal_ie    = pwdata_in[BIT_NORMAL_IE];
          next_st.abnormal_ie  = pwdata_in[BIT_ABNORMAL_IE];
          next_st.rsvd21       = pwdata_in[BIT_RSVD21];
          next_st.big_endian   = pwdata_in[BIT_BIG_ENDIAN];
          next_st.source_sel   = pwdata_in[BIT_SOURCE_SEL];
          next_st.polarity_sel = pwdata_in[BIT_POLARITY];
          next_st.level_mode   = pwdata_in[BIT_LEVEL_MODE];
        end
        ADDR_IRQ_CLR:
        begin
          next_st.irq_clr = pwdata_in[IRQ_W-1:0];
        end
        ADDR_STATUS:
        begin
          // read-only; the write completes without error and is dropped
          next_st.irq_clr = '0;
        end
        ADDR_CHAN:
        begin
          // the state belongs to the sequencer below
          next_st.irq_clr = '0;
        end
        ADDR_IRQ_EN:
        begin
          next_st.irq_en = pwdata_in[IRQ_W-1:0];
        end
        default:
        begin
          next_st.irq_clr = '0;
        end
      endcase
    end

    // request guard countdown
    if (ctrl_wr)
    begin
      next_st.settle = REQ_SETTLE;
    end
    else if (st.settle != 2'h0)
    begin
      next_st.settle = st.settle - 2'h1;
    end

    // channel sequencing
    unique case (st.state)
      DCF_IDLE:
      begin
        // the new request mode is used, so start and mode may share one write
        if (start_wr)
        begin
          if (next_st.source_sel)
          begin
            next_st.state = DCF_READY;
          end
          else
          begin
            next_st.state    = DCF_XFER;
            next_st.xfer_req = 1'b1;
          end
        end
      end
      DCF_READY:
      begin
        // polarity and edge only shape ext_req, which is 0 in internal mode
        if (ext_ok)
        begin
          next_st.state    = DCF_XFER;
          next_st.xfer_req = 1'b1;
        end
        else if (start_wr && !next_st.source_sel)
        begin
          next_st.state    = DCF_XFER;
          next_st.xfer_req = 1'b1;
        end
      end
      DCF_XFER:
      begin
        // abnormal ends the transfer just like normal; only the flag differs
        if (normal_done_in || abnormal_done_in)
        begin
          next_st.state = DCF_IDLE;
        end
      end
      default:
      begin
        next_st.state = DCF_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      st.normal_ie    <= RST_NORMAL_IE;
      st.abnormal_ie  <= RST_ABNORMAL_IE;
      st.rsvd21       <= RST_RSVD21;
      st.big_endian   <= RST_BIG_ENDIAN;
      st.source_sel   <= RST_SOURCE_SEL;
      st.polarity_sel <= RST_POLARITY;
      st.level_mode   <= RST_LEVEL_MODE;
      st.state        <= DCF_IDLE;
      st.xfer_req     <= 1'b0;
      st.settle       <= 2'h0;
      st.irq_en       <= RST_IRQ_EN;
      st.irq_clr      <= '0;
      st.pready       <= 1'b0;
      st.pslverr      <= 1'b0;
      st.prdata       <= 32'h0000_0000;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign prdata_out           = st.prdata;
  assign pready_out           = st.pready;
  assign pslverr_out          = st.pslverr;
  assign transfer_request_out = st.xfer_req;
  assign big_endian_out       = st.big_endian;
  assign channel_state_out    = st.state;
endmodule

// ==== dcf_pkg.sv ====
package dcf_pkg;
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
  localparam logic [7:0] ADDR_CHAN    = 8'h10;
  localparam int BIT_START       = 31;
  localparam int BIT_NORMAL_IE   = 23;
  localparam int BIT_ABNORMAL_IE = 22;
  localparam int BIT_RSVD21      = 21;
  localparam int BIT_BIG_ENDIAN  = 17;
  localparam int BIT_SOURCE_SEL  = 14;
  localparam int BIT_POLARITY    = 13;
  localparam int BIT_LEVEL_MODE  = 12;
  localparam logic RST_NORMAL_IE   = 1'h1;
  localparam logic RST_ABNORMAL_IE = 1'h1;
  localparam logic RST_RSVD21      = 1'h1;
  localparam logic RST_BIG_ENDIAN  = 1'h1;
  localparam logic RST_SOURCE_SEL  = 1'h0;
  localparam logic RST_POLARITY    = 1'h0;
  localparam logic RST_LEVEL_MODE  = 1'h0;
  localparam int IRQ_W            = 3;
  localparam int IRQ_NORMAL       = 0;
  localparam int IRQ_ABNORMAL     = 1;
  localparam int IRQ_EXT_REQ      = 2;
  localparam logic [IRQ_W-1:0] RST_IRQ_EN = 3'h0;
  localparam logic [1:0]       REQ_SETTLE = 2'h2;
  typedef enum logic [1:0] {
    DCF_IDLE  = 2'b00,
    DCF_READY = 2'b01,
    DCF_XFER  = 2'b10
  } dcf_ch_state_t;
endpackage

// ==== dcf_req_if.sv ====
`timescale 1ns/100ps
interface dcf_req_if;
  logic source_sel;
  logic polarity_sel;
  logic level_mode;
  logic request;
  modport ctl (output source_sel, output polarity_sel, output level_mode, input request);
  modport det (input source_sel, input polarity_sel, input level_mode, output request);
endinterface

// ==== dcf_req_detect.sv ====
`timescale 1ns/100ps
module dcf_req_detect (
  input  wire logic core_clk_in,
  input  wire logic rstn_in,
  input  wire logic ext_transfer_request_in,
  dcf_req_if.det    req
);
  import dcf_pkg::*;
  typedef struct packed {
    logic [1:0] sync;
    logic       prev;
    logic       request;
  } dcf_det_st_t;
  dcf_det_st_t st;
  dcf_det_st_t next_st;
  logic        active;

  always_comb
  begin
    next_st = st;
    // only the second stage is looked at; the first may be metastable
    next_st.sync = {st.sync[0], ext_transfer_request_in};
    active = req.polarity_sel ? st.sync[1] : ~st.sync[1];
    next_st.prev = active;
    if (req.level_mode)
      next_st.request = req.source_sel & active;
    else
      next_st.request = req.source_sel & active & ~st.prev;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign req.request = st.request;
endmodule

// ==== dcf_irq_status.sv ====
`timescale 1ns/100ps
module dcf_irq_status #(
  parameter int N = 3
) (
  input  wire logic         core_clk_in,
  input  wire logic         rstn_in,
  input  wire logic [N-1:0] event_in,
  input  wire logic [N-1:0] enable_in,
  input  wire logic [N-1:0] clear_in,
  output logic      [N-1:0] status_out,
  output logic              irq_out
);
  typedef struct packed {
    logic [N-1:0] status;
    logic         irq;
  } dcf_irq_st_t;
  dcf_irq_st_t st;
  dcf_irq_st_t next_st;

  always_comb
  begin
    next_st = st;
    // an event landing with its clear is kept: set beats clear
    next_st.status = (st.status & ~clear_in) | event_in;
    next_st.irq    = |(next_st.status & enable_in);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign status_out = st.status;
  assign irq_out    = st.irq;
endmodule

// ==== dcf_channel_ctrl_checker.sv ====
`timescale 1ns/100ps
module dcf_channel_ctrl_checker
  import dcf_pkg::*;
(
  input wire logic          core_clk_in,
  input wire logic          rstn_in,
  input wire logic          psel_in,
  input wire logic          penable_in,
  input wire logic          pwrite_in,
  input wire logic [7:0]    paddr_in,
  input wire logic [31:0]   pwdata_in,
  input wire logic [31:0]   prdata_out,
  input wire logic          pready_out,
  input wire logic          pslverr_out,
  input wire logic          ext_transfer_request_in,
  input wire logic          normal_done_in,
  input wire logic          abnormal_done_in,
  input wire logic          transfer_request_out,
  input wire logic          big_endian_out,
  input wire dcf_ch_state_t channel_state_out,
  input wire logic          irq_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // =====
  // bus cycle steps
  sequence s_access;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence s_ctrl_wr;
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == ADDR_CTRL;
  endsequence
  sequence s_start(logic ext);
    s_ctrl_wr ##0 (pwdata_in[BIT_START] && pwdata_in[BIT_SOURCE_SEL] == ext
      && channel_state_out == DCF_IDLE);
  endsequence
  // =====
  // properties
  AST_ONE_WAIT: assert property (s_access |=> pready_out)
    else $error("access phase not answered after one wait state");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("pready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("error response without pready");
  AST_RDATA_IDLE: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data not zero outside the answer cycle");
  AST_BIG_WRITE: assert property (s_ctrl_wr |=> big_endian_out == $past(pwdata_in[17]))
    else $error("byte order output does not follow the written bit");
  AST_INT_START: assert property (s_start(1'b0) |=>
    transfer_request_out && channel_state_out == DCF_XFER)
    else $error("software start did not request a transfer");
  AST_EXT_START: assert property (s_start(1'b1) |=>
    !transfer_request_out && channel_state_out == DCF_READY)
    else $error("external mode start did not wait for the pin");
  AST_REQ_CAUSE: assert property (transfer_request_out |->
    $past(channel_state_out) == DCF_READY
    || $past(psel_in && penable_in && pready_out && pwrite_in && pwdata_in[BIT_START]))
    else $error("transfer request without start or armed external mode");
  AST_REQ_PULSE: assert property (transfer_request_out |=> !transfer_request_out)
    else $error("transfer request longer than one cycle");
  AST_DONE_IDLE: assert property (channel_state_out == DCF_XFER
    && (normal_done_in || abnormal_done_in) |=> channel_state_out == DCF_IDLE)
    else $error("channel did not return to idle on completion");
endmodule

// ==== dcf_channel_ctrl_bench.sv ====
`timescale 1ns/100ps
bind dcf_channel_ctrl dcf_channel_ctrl_checker chk (.core_clk_in(core_clk_in),
  .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .ext_transfer_request_in(ext_transfer_request_in), .normal_done_in(normal_done_in),
  .abnormal_done_in(abnormal_done_in), .transfer_request_out(transfer_request_out),
  .big_endian_out(big_endian_out), .channel_state_out(channel_state_out),
  .irq_out(irq_out));
module dcf_channel_ctrl_bench;
  import dcf_pkg::*;
  logic          core_clk_in, rstn_in, psel_in, penable_in, pwrite_in, pready_out;
  logic          pslverr_out, ext_transfer_request_in, normal_done_in, abnormal_done_in;
  logic          transfer_request_out, big_endian_out, irq_out, last_err;
  logic [7:0]    paddr_in;
  logic [31:0]   pwdata_in, prdata_out;
  dcf_ch_state_t channel_state_out;
  int            failures, checked;
  dcf_channel_ctrl uut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .ext_transfer_request_in(ext_transfer_request_in),
    .normal_done_in(normal_done_in), .abnormal_done_in(abnormal_done_in),
    .transfer_request_out(transfer_request_out), .big_endian_out(big_endian_out),
    .channel_state_out(channel_state_out), .irq_out(irq_out));
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  // =====
  // helpers
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; one wait state expected but not assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    r = prdata_out;
    last_err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      final_report();
    end
    // one idle edge, so a following setup never rewrites psel in this step
    @(posedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    apb(1'b0, a, 32'h0, x);
    check_word(x, e);
  endtask
  task automatic pulse(input logic [1:0] m);
    {abnormal_done_in, normal_done_in} <= m;
    @(posedge core_clk_in);
    {abnormal_done_in, normal_done_in} <= 2'h0;
  endtask
  task automatic wait_req;
    int n;
    n = 0;
    while (transfer_request_out !== 1'b1 && n < 20)
    begin
      @(posedge core_clk_in);
      n++;
    end
    check_word({31'h0, transfer_request_out}, 32'h1);
    if (n >= 20)
      final_report();
  endtask
  // =====
  // tests
  initial
  begin
    {rstn_in, psel_in, penable_in, pwrite_in, normal_done_in, abnormal_done_in} = 6'h0;
    paddr_in = 8'h0;
    pwdata_in = 32'h0;
    failures = 0;
    checked = 0;
    ext_transfer_request_in = 1'b1;
    repeat (12) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(posedge core_clk_in);
    check_word({31'h0, big_endian_out}, 32'h1);
    check_word({30'h0, channel_state_out}, 32'h0);
    rd_chk(ADDR_CTRL, 32'h00E2_0000);
    rd_chk(8'h14, 32'h0);
    check_word({31'h0, last_err}, 32'h1);
    $display("test done: reset");
    wr(ADDR_CTRL, 32'h00C2_7000);
    rd_chk(ADDR_CTRL, 32'h00C2_7000);
    wr(ADDR_CTRL, 32'h0000_1000);
    rd_chk(ADDR_CTRL, 32'h0000_1000);
    check_word({31'h0, big_endian_out}, 32'h0);
    $display("test done: access");
    // pin held active low while internal mode must ignore it
    ext_transfer_request_in <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    wr(ADDR_CTRL, 32'h8000_1000);
    wait_req();
    rd_chk(ADDR_CHAN, 32'h2);
    pulse(2'h1);
    rd_chk(ADDR_CHAN, 32'h0);
    ext_transfer_request_in <= 1'b1;
    $display("test done: internal start");
    wr(ADDR_CTRL, 32'h00C0_1000);
    wr(ADDR_IRQ_EN, 32'h7);
    for (int i = 0; i < 2; i++)
    begin
      pulse(2'(1 << i));
      rd_chk(ADDR_STATUS, 32'(1 << i));
      check_word({31'h0, irq_out}, 32'h1);
      wr(ADDR_IRQ_EN, 32'h0);
      repeat (2) @(posedge core_clk_in);
      check_word({31'h0, irq_out}, 32'h0);
      wr(ADDR_IRQ_EN, 32'h7);
      wr(ADDR_IRQ_CLR, 32'(1 << i));
      repeat (2) @(posedge core_clk_in);
      check_word({31'h0, irq_out}, 32'h0);
      rd_chk(ADDR_STATUS, 32'h0);
    end
    wr(ADDR_CTRL, 32'h0000_1000);
    pulse(2'h3);
    rd_chk(ADDR_STATUS, 32'h0);
    $display("test done: interrupts");
    // the second pass flips polarity while the pin sits at the old active
    // level: the channel must stay ready until the pin really goes valid
    for (int p = 0; p < 2; p++)
    begin
      ext_transfer_request_in <= ~p[0];
      wr(ADDR_CTRL, 32'h8000_5000 | 32'(p << 13));
      rd_chk(ADDR_CHAN, 32'h1);
      ext_transfer_request_in <= p[0];
      wait_req();
      rd_chk(ADDR_CHAN, 32'h2);
      rd_chk(ADDR_STATUS, 32'h4);
      ext_transfer_request_in <= ~p[0];
      wr(ADDR_IRQ_CLR, 32'h4);
      pulse(2'h2);
      rd_chk(ADDR_CHAN, 32'h0);
    end
    $display("test done: external request");
    final_report();
  end
endmodule
